/* File: psd_consts.svh */
// constants for the phy status and diagnostic register group
`ifndef PSD_CONSTS_SVH
`define PSD_CONSTS_SVH

// ------------------------------------------------------------
// register addresses (smi register numbers)
// ------------------------------------------------------------
`define PSD_ADDR_GEN_STATUS  5'h18
`define PSD_ADDR_EXT_STATUS  5'h19
`define PSD_ADDR_LINK_FAIL   5'h1a

// ------------------------------------------------------------
// general status field positions
// ------------------------------------------------------------
`define PSD_GS_INT_BIT       15
`define PSD_GS_PLL_BIT       14
`define PSD_GS_WLOC_BIT      13
`define PSD_GS_WLINE_BIT     12
`define PSD_GS_WTRAF_BIT     11
`define PSD_GS_EN_BIT        10
`define PSD_GS_RST_BIT       9
`define PSD_GS_LCNT_MSB      7
`define PSD_GS_LCNT_LSB      3

// ------------------------------------------------------------
// external status field positions
// ------------------------------------------------------------
`define PSD_ES_UV_MSB        14
`define PSD_ES_UV_LSB        11
`define PSD_ES_THIGH_BIT     10
`define PSD_ES_TWARN_BIT     9
`define PSD_ES_SHORT_BIT     8
`define PSD_ES_OPEN_BIT      7
`define PSD_ES_ILV_BIT       5

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define PSD_LCNT_RST         5'h00
`define PSD_RXCNT_RST        8'h00
`define PSD_RXCNT_MAX        8'hff
`define PSD_LCNT_MAX         5'h1f
`define PSD_SYNC_RST         1'b0
`define PSD_IDLE_PLL         1'b1
`define PSD_IDLE_EN          1'b1

`endif

/* File: psd_pkg.sv */
// types shared by the phy status and diagnostic register group
package psd_pkg;

	// ------------------------------------------------------------
	// raw event inputs from the phy
	// ------------------------------------------------------------
	typedef struct packed {
		logic       int_pending;  // unmasked interrupt pending
		logic       pll_locked;   // pll lock level
		logic       wake_local;   // local wake-up event
		logic       wake_line;    // remote wake-up over the line
		logic       sleep_req;    // sleep request mode active
		logic       pcs_rx_dv;    // valid line data
		logic       tx_en;        // mac transmit enable
		logic       enable;       // enable pin level
		logic       link_fail;    // link fail pulse
		logic [3:0] uv;           // undervoltage: a3v3, d1v8, a1v8, io
		logic       temp_high;    // over high temperature
		logic       temp_warn;    // over warning temperature
		logic       cable_short;  // short detected
		logic       cable_open;   // open detected
		logic       ilv_swap;     // interleave order b then a
		logic       near_rx_bad;  // local receiver not ok
		logic       far_rx_bad;   // remote receiver not ok
	} psd_evt_s;

	// read request to the register group
	typedef struct packed {
		logic       rd;           // one-cycle read strobe
		logic [4:0] addr;         // register number
	} psd_rd_s;

	typedef logic [15:0] psd_word_t;

endpackage : psd_pkg

/* File: psd_sync.sv */
// two flop synchroniser bank for asynchronous status levels
`timescale 1ns/10ps
module psd_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0   // level both stages take in reset
) (
	input  wire logic         mclk_in,     // system clock
	input  wire logic         reset_n_in,  // sync reset, active low
	input  wire logic [W-1:0] async_in,    // asynchronous levels
	output logic      [W-1:0] sync_out     // synchronised levels
);
	logic [W-1:0] meta_ff;  // first stage, read only by second

	// ------------------------------------------------------------
	// two stages per bit
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			meta_ff  <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : psd_sync

/* File: psd_satcnt.sv */
// saturating event counter with clear on read
`timescale 1ns/10ps
module psd_satcnt #(
	parameter int W = 8
) (
	input  wire logic         mclk_in,     // system clock
	input  wire logic         reset_n_in,  // sync reset, active low
	input  wire logic         inc_in,      // count one event
	input  wire logic         clr_in,      // clear by read
	output logic      [W-1:0] cnt_out      // counter value
);
	wire full_w = &cnt_out;  // saturated

	// ------------------------------------------------------------
	// count, hold at full, clear keeps a same cycle event
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			cnt_out <= '0;
		end else if (clr_in) begin
			cnt_out <= {{(W-1){1'b0}}, inc_in};
		end else if (inc_in && !full_w) begin
			cnt_out <= cnt_out + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule : psd_satcnt

/* File: psd_status_regs.sv */
// status and diagnostic registers of the phy, read over the smi
`timescale 1ns/10ps
`include "psd_consts.svh"

// Functional notes
// [RL1] bit 15 shows unmasked interrupt pending
// [RL2] bit 14 pll lock, latched low
// [RL3] bit 13 latches local wake-up
// [RL4] bit 12 latches line wake-up
// [RL5] bit 11 traffic seen in sleep request
// [RL6] bit 10 latches enable low
// [RL7] bit 9 hardware reset seen since read
// [RL8] bits 7:3 count link fails since read
// [RL9] reserved bits always read zero
// [RL10] bits 14:11 latch supply undervoltage
// [RL11] bit 10 latches high temperature
// [RL12] bit 9 latches temperature warning
// [RL13] bit 8 latches cable short
// [RL14] bit 7 latches cable open
// [RL15] bit 5 reports interleave order
// [RL16] upper byte counts local receiver faults
// [RL17] lower byte counts remote receiver faults
// [RL18] read clears both receiver counters
// [RL19] link control off keeps counts
// [RL20] latched bits hold until read
module psd_status_regs
	import psd_pkg::*;
(
	input  wire logic      mclk_in,        // 100 mhz system clock
	input  wire logic      reset_n_in,     // sync reset, active low
	input  wire psd_rd_s   rd_req_in,      // smi read strobe and address
	input  wire psd_evt_s  evt_in,         // raw phy status inputs
	input  wire logic      link_ctrl_in,   // link control enable
	output psd_word_t      rd_data_out,    // read data, registered
	output logic           rd_valid_out    // read data valid pulse
);

	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	psd_evt_s evt_s;  // synchronised events

	// reset loads the idle pin levels, so that the enable-low and pll-loss
	// latches see no false event while the stages refill after release
	localparam psd_evt_s SYNC_IDLE = '{pll_locked: `PSD_IDLE_PLL, enable: `PSD_IDLE_EN,
		default: '0};

	psd_sync #(
		.W       ($bits(psd_evt_s)),
		.RST_VAL (SYNC_IDLE)
	) u_sync (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.async_in   (evt_in),
		.sync_out   (evt_s)
	);

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	wire rd_gs_w = rd_req_in.rd && (rd_req_in.addr == `PSD_ADDR_GEN_STATUS);  // gs read
	wire rd_es_w = rd_req_in.rd && (rd_req_in.addr == `PSD_ADDR_EXT_STATUS);  // es read
	wire rd_lf_w = rd_req_in.rd && (rd_req_in.addr == `PSD_ADDR_LINK_FAIL);   // lf read
	// link control off only freezes the interleave order flag; no flag is cleared by it
	wire lc_off_w = !link_ctrl_in;

	// ------------------------------------------------------------
	// latched flags
	// ------------------------------------------------------------
	logic       pll_ll_ff;      // pll lock, latched low
	logic       wake_local_flag_ff;
	logic       wake_line_flag_ff;
	logic       wake_on_traffic_flag_ff;
	logic       en_low_ff;      // enable went low
	logic       hw_reset_ff;    // reset seen since read
	logic [3:0] uv_ff;          // supply undervoltage flags
	logic       temp_high_ff;   // high temperature flag
	logic       temp_warn_ff;   // warning temperature flag
	logic       short_ff;       // cable short flag
	logic       open_ff;        // cable open flag
	logic       ilv_ff;         // interleave order
	logic [4:0] link_loss_count_ff;
	logic       lf_d_ff;        // link fail delayed for edge

	// traffic in sleep request mode
	// [RL5] traffic wake cause
	wire traffic_w = evt_s.sleep_req && (evt_s.pcs_rx_dv || evt_s.tx_en);
	wire lf_rise_w = evt_s.link_fail && !lf_d_ff;  // one count per fail
	wire lcnt_full_w = (link_loss_count_ff == `PSD_LCNT_MAX);  // hold at max

	// ------------------------------------------------------------
	// latch-until-read flags of general status; set wins over read
	// ------------------------------------------------------------
	// [RL20] set beats read clear
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			pll_ll_ff               <= 1'b0;
			wake_local_flag_ff      <= 1'b0;
			wake_line_flag_ff       <= 1'b0;
			wake_on_traffic_flag_ff <= 1'b0;
			en_low_ff               <= 1'b0;
			hw_reset_ff             <= 1'b1;
		end else begin
			// [RL2] latch low lock
			pll_ll_ff               <= (rd_gs_w ? 1'b1 : pll_ll_ff) & evt_s.pll_locked;
			// [RL3] local wake latch
			wake_local_flag_ff      <= evt_s.wake_local | (wake_local_flag_ff & ~rd_gs_w);
			// [RL4] line wake latch
			wake_line_flag_ff       <= evt_s.wake_line | (wake_line_flag_ff & ~rd_gs_w);
			// [RL5] traffic wake latch
			wake_on_traffic_flag_ff <= traffic_w | (wake_on_traffic_flag_ff & ~rd_gs_w);
			// [RL6] enable low latch
			en_low_ff               <= ~evt_s.enable | (en_low_ff & ~rd_gs_w);
			// [RL7] reset seen clears on read
			hw_reset_ff             <= hw_reset_ff & ~rd_gs_w;
		end
	end

	// ------------------------------------------------------------
	// link fail counter field, held across link control off
	// ------------------------------------------------------------
	// [RL8] count link fails
	// [RL19] not cleared by link control
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			link_loss_count_ff <= `PSD_LCNT_RST;
			lf_d_ff            <= `PSD_SYNC_RST;
		end else begin
			lf_d_ff <= evt_s.link_fail;
			if (rd_gs_w) begin
				link_loss_count_ff <= {4'h0, lf_rise_w};
			end else if (lf_rise_w && !lcnt_full_w) begin
				link_loss_count_ff <= link_loss_count_ff + 5'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// external status flags
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			uv_ff        <= 4'h0;
			temp_high_ff <= 1'b0;
			temp_warn_ff <= 1'b0;
			short_ff     <= 1'b0;
			open_ff      <= 1'b0;
			ilv_ff       <= 1'b0;
		end else begin
			// [RL10] undervoltage latches
			uv_ff        <= evt_s.uv | (uv_ff & {4{~rd_es_w}});
			// [RL11] high temperature latch
			temp_high_ff <= evt_s.temp_high | (temp_high_ff & ~rd_es_w);
			// [RL12] warning temperature latch
			temp_warn_ff <= evt_s.temp_warn | (temp_warn_ff & ~rd_es_w);
			// [RL13] short latch, kept
			short_ff     <= evt_s.cable_short | (short_ff & ~rd_es_w);
			// [RL14] open latch, kept
			open_ff      <= evt_s.cable_open | (open_ff & ~rd_es_w);
			// [RL15] interleave order, kept while link control off
			if (!lc_off_w) begin
				ilv_ff <= evt_s.ilv_swap;
			end
		end
	end

	// ------------------------------------------------------------
	// receiver fault counters
	// ------------------------------------------------------------
	logic [7:0] near_rx_fault_count;  // local receiver faults
	logic [7:0] far_rx_fault_count;   // remote receiver faults

	// [RL16] local receiver count
	// [RL18] read clears count
	psd_satcnt #(
		.W (8)
	) u_near_cnt (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.inc_in     (evt_s.near_rx_bad),
		.clr_in     (rd_lf_w),
		.cnt_out    (near_rx_fault_count)
	);

	// [RL17] remote receiver count
	psd_satcnt #(
		.W (8)
	) u_far_cnt (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.inc_in     (evt_s.far_rx_bad),
		.clr_in     (rd_lf_w),
		.cnt_out    (far_rx_fault_count)
	);

	// ------------------------------------------------------------
	// read word assembly
	// ------------------------------------------------------------
	psd_word_t gs_w;  // general status word
	psd_word_t es_w;  // external status word
	psd_word_t lf_w;  // receiver fault counter word

	// [RL1] interrupt summary
	// [RL9] reserved bits zero
	assign gs_w = {evt_s.int_pending, pll_ll_ff, wake_local_flag_ff,
		wake_line_flag_ff, wake_on_traffic_flag_ff, en_low_ff, hw_reset_ff,
		1'b0, link_loss_count_ff, 3'h0};
	assign es_w = {1'b0, uv_ff, temp_high_ff, temp_warn_ff, short_ff, open_ff,
		1'b0, ilv_ff, 5'h00};
	assign lf_w = {near_rx_fault_count, far_rx_fault_count};

	wire psd_word_t nxt_rd_data = rd_gs_w ? gs_w :
		rd_es_w ? es_w :
		rd_lf_w ? lf_w : 16'h0000;  // unmapped reads zero

	// ------------------------------------------------------------
	// registered read data
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			rd_data_out  <= 16'h0000;
			rd_valid_out <= 1'b0;
		end else begin
			rd_data_out  <= nxt_rd_data;
			rd_valid_out <= rd_req_in.rd;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);

	gs_reserved_a: assert property (  // [RL9]
		rd_valid_out && $past(rd_gs_w) |-> (rd_data_out[8] == 1'b0 && rd_data_out[2:0] == 3'h0))
		else $error("reserved general status bits not zero");
	es_reserved_a: assert property (  // [RL9]
		rd_valid_out && $past(rd_es_w) |-> (rd_data_out[15] == 1'b0 && rd_data_out[6] == 1'b0
		&& rd_data_out[4:0] == 5'h00))
		else $error("reserved external status bits not zero");
	wake_hold_a: assert property (  // [RL3]
		evt_s.wake_local && !rd_gs_w ##1 !rd_gs_w |=> wake_local_flag_ff)
		else $error("local wake flag lost before read");
	pll_low_a: assert property (  // [RL2]
		!evt_s.pll_locked ##1 !rd_gs_w |-> !pll_ll_ff)
		else $error("pll lock loss not latched");
	traffic_set_a: assert property (  // [RL5]
		traffic_w |=> wake_on_traffic_flag_ff)
		else $error("traffic in sleep request not latched");
	cnt_clear_a: assert property (  // [RL18]
		rd_lf_w && !evt_s.near_rx_bad |=> near_rx_fault_count == 8'h00)
		else $error("receiver counter not cleared on read");
	cnt_sat_a: assert property (  // [RL16]
		near_rx_fault_count == 8'hff && !rd_lf_w |=> near_rx_fault_count == 8'hff)
		else $error("receiver counter wrapped");
	far_inc_a: assert property (  // [RL17]
		evt_s.far_rx_bad && !rd_lf_w && far_rx_fault_count != 8'hff
		|=> far_rx_fault_count == $past(far_rx_fault_count) + 8'h01)
		else $error("remote counter did not step");
	lcnt_keep_a: assert property (  // [RL19]
		lc_off_w && !rd_gs_w && !lf_rise_w |=> $stable(link_loss_count_ff))
		else $error("link fail count changed with link control off");
	int_bit_a: assert property (  // [RL1]
		rd_gs_w |=> rd_data_out[15] == $past(evt_s.int_pending))
		else $error("interrupt summary bit wrong");
	// per-field set, hold, clear, saturation and unmapped read checks
	hw_reset_clr_a: assert property (  // [RL7]
		rd_gs_w |=> !hw_reset_ff)
		else $error("reset seen flag not cleared by read");
	en_low_set_a: assert property (  // [RL6]
		!evt_s.enable |=> en_low_ff)
		else $error("enable low not latched");
	line_wake_a: assert property (  // [RL4]
		evt_s.wake_line |=> wake_line_flag_ff)
		else $error("line wake-up not latched");
	lcnt_sat_a: assert property (  // [RL8]
		link_loss_count_ff == `PSD_LCNT_MAX && !rd_gs_w
		|=> link_loss_count_ff == `PSD_LCNT_MAX)
		else $error("link fail count left saturation");
	uv_set_a: assert property (  // [RL10]
		evt_s.uv != 4'h0 |=> (uv_ff & $past(evt_s.uv)) == $past(evt_s.uv))
		else $error("undervoltage flag not latched");
	temp_high_a: assert property (  // [RL11]
		evt_s.temp_high |=> temp_high_ff)
		else $error("high temperature not latched");
	short_hold_a: assert property (  // [RL13]
		short_ff && !rd_es_w |=> short_ff)
		else $error("short flag dropped before read");
	open_hold_a: assert property (  // [RL14]
		open_ff && !rd_es_w |=> open_ff)
		else $error("open flag dropped before read");
	ilv_hold_a: assert property (  // [RL15]
		lc_off_w |=> $stable(ilv_ff))
		else $error("interleave bit moved with link control off");
	unmapped_zero_a: assert property (  // [RL9]
		rd_req_in.rd && !rd_gs_w && !rd_es_w && !rd_lf_w |=> rd_data_out == 16'h0000)
		else $error("unmapped read not zero");

	read_gs_c: cover property (rd_gs_w ##1 rd_valid_out);
	lc_off_c:  cover property (lc_off_w && near_rx_fault_count != 8'h00);
	read_lf_c: cover property (rd_lf_w && near_rx_fault_count != 8'h00);
	cnt_sat_c: cover property (far_rx_fault_count == 8'hff);
	uv_set_c:  cover property (uv_ff != 4'h0 ##1 rd_es_w);

endmodule : psd_status_regs

/* File: psd_smi_host.sv */
// station management read master model for the status registers
`timescale 1ns/10ps
module psd_smi_host
	import psd_pkg::*;
(
	input  wire logic      mclk_in,      // system clock
	input  wire logic      rd_valid_in,  // read data valid pulse
	input  wire psd_word_t rd_data_in,   // read data
	output psd_rd_s        rd_req_out    // read strobe and address
);
	// idle: strobe low, address parked
	initial begin
		rd_req_out = '{1'b0, 5'h1f};
	end

	// ------------------------------------------------------------
	// one read cycle, optional idle gap before the strobe
	// ------------------------------------------------------------
	task automatic do_read(input logic [4:0] a, input int gap, output psd_word_t d);
		int n;
		n = 0;
		d = 16'hxxxx;
		repeat (gap) @(posedge mclk_in);
		@(posedge mclk_in);
		rd_req_out <= '{1'b1, a};
		@(posedge mclk_in);
		// released address is inverted so stale values never match
		rd_req_out <= '{1'b0, ~a};
		do begin
			@(posedge mclk_in);
			n++;
		end while (rd_valid_in !== 1'b1 && n < 4);
		if (rd_valid_in === 1'b1) begin
			d = rd_data_in;
		end
	endtask : do_read
endmodule : psd_smi_host

/* File: tb_psd_status_regs.sv */
// self-checking testbench for the status and diagnostic registers
`timescale 1ns/10ps
module tb_psd_status_regs
	import psd_pkg::*;
;
	logic      mclk_in;      // 100 mhz clock
	logic      reset_n_ff;   // sync reset, active low
	psd_evt_s  evt_ff;       // event levels
	logic      link_ctrl_ff; // link control enable
	psd_rd_s   rd_req;       // read request from the host
	psd_word_t rd_data;      // read data
	logic      rd_valid;     // read valid
	psd_word_t got;          // last read word
	int        err_count;    // mismatches
	int        checked;      // comparisons

	typedef struct {
		int        k;        // event pattern
		logic [4:0] a;       // address
		psd_word_t exp;      // expected word while event held
	} psd_row_s;
	psd_row_s rows[$] = '{
		'{1, 5'h18, 16'hc000},
		'{2, 5'h18, 16'h0000},
		'{3, 5'h18, 16'h6000},
		'{4, 5'h18, 16'h5000},
		'{5, 5'h18, 16'h4800},
		'{6, 5'h18, 16'h4800},
		'{17, 5'h18, 16'h4000},
		'{7, 5'h18, 16'h4400},
		'{8, 5'h19, 16'h4000},
		'{9, 5'h19, 16'h2000},
		'{10, 5'h19, 16'h1000},
		'{11, 5'h19, 16'h0800},
		'{12, 5'h19, 16'h0400},
		'{13, 5'h19, 16'h0200},
		'{14, 5'h19, 16'h0100},
		'{15, 5'h19, 16'h0080},
		'{16, 5'h19, 16'h0020},
		'{18, 5'h18, 16'hf808},
		'{18, 5'h19, 16'h7fa0},
		'{18, 5'h1b, 16'h0000}
	};

	psd_status_regs psd_status_regs_inst (
		.mclk_in      (mclk_in),
		.reset_n_in   (reset_n_ff),
		.rd_req_in    (rd_req),
		.evt_in       (evt_ff),
		.link_ctrl_in (link_ctrl_ff),
		.rd_data_out  (rd_data),
		.rd_valid_out (rd_valid)
	);
	psd_smi_host psd_smi_host_inst (
		.mclk_in     (mclk_in),
		.rd_valid_in (rd_valid),
		.rd_data_in  (rd_data),
		.rd_req_out  (rd_req)
	);

	// clock generator
	initial mclk_in = 1'b0;
	always #5 mclk_in = ~mclk_in;

	// event pattern: idle is pll locked and enable high
	function automatic psd_evt_s ev(input int k);
		psd_evt_s e;
		e = '0;
		e.pll_locked = 1'b1;
		e.enable = 1'b1;
		case (k)
			1: e.int_pending = 1'b1;
			2: e.pll_locked = 1'b0;
			3: e.wake_local = 1'b1;
			4: e.wake_line = 1'b1;
			5: e = '{sleep_req: 1'b1, pcs_rx_dv: 1'b1, pll_locked: 1'b1, enable: 1'b1, default: '0};
			6: e = '{sleep_req: 1'b1, tx_en: 1'b1, pll_locked: 1'b1, enable: 1'b1, default: '0};
			7: e.enable = 1'b0;
			8, 9, 10, 11: e.uv = 4'h8 >> (k - 8);
			12: e.temp_high = 1'b1;
			13: e.temp_warn = 1'b1;
			14: e.cable_short = 1'b1;
			15: e.cable_open = 1'b1;
			16: e.ilv_swap = 1'b1;
			17: e.pcs_rx_dv = 1'b1;
			18: e = '1;
			default: ;
		endcase
		return e;
	endfunction : ev

	// compare and count
	task automatic check(input psd_word_t g, input psd_word_t x);
		checked++;
		if (g !== x) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask : check

	task automatic rd(input logic [4:0] a);
		psd_smi_host_inst.do_read(a, 0, got);
	endtask : rd

	// hold a pattern for hi cycles, then idle for lo cycles
	task automatic pulse(input int k, input int hi, input int lo);
		@(posedge mclk_in);
		evt_ff <= ev(k);
		repeat (hi) @(posedge mclk_in);
		evt_ff <= ev(0);
		repeat (lo) @(posedge mclk_in);
	endtask : pulse

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	// watchdog
	initial begin
		#200000;
		err_count++;
		conclude();
	end

	initial begin
		err_count = 0;
		checked = 0;
		reset_n_ff = 1'b0;
		evt_ff = ev(0);
		link_ctrl_ff = 1'b1;
		repeat (4) @(posedge mclk_in);
		reset_n_ff <= 1'b1;
		// ------------------------------------------------------------
		// reset values
		// ------------------------------------------------------------
		rd(5'h18); check(got, 16'h0200);
		rd(5'h18); check(got, 16'h4000);
		rd(5'h1a); check(got, 16'h0000);
		$display("test reset done");
		// ------------------------------------------------------------
		// table of single events and of all events at once, then clear on read
		// ------------------------------------------------------------
		foreach (rows[i]) begin
			pulse(rows[i].k, 5, 0);
			rd(rows[i].a); check(got, rows[i].exp);
			pulse(0, 5, 0);
			rd(rows[i].a);
			psd_smi_host_inst.do_read(rows[i].a, 2, got);
			check(got, (rows[i].a == 5'h18) ? 16'h4000 : 16'h0000);
			$display("row %0d done", i);
		end
		rd(5'h18);
		rd(5'h1a);
		// ------------------------------------------------------------
		// link fail count and saturation
		// ------------------------------------------------------------
		for (int i = 0; i < 3; i++) begin
			pulse(18, 1, 2);
		end
		rd(5'h1a);
		rd(5'h18); check(got, 16'h7818);
		for (int i = 0; i < 40; i++) begin
			pulse(18, 1, 2);
		end
		rd(5'h1a);
		rd(5'h18); check(got, 16'h78f8);
		rd(5'h18); check(got, 16'h4000);
		$display("test link fail done");
		// ------------------------------------------------------------
		// receiver counters: exact count, saturation, clear
		// ------------------------------------------------------------
		rd(5'h19);
		@(posedge mclk_in);
		evt_ff <= '{near_rx_bad: 1'b1, far_rx_bad: 1'b1, pll_locked: 1'b1, enable: 1'b1,
			default: '0};
		repeat (5) @(posedge mclk_in);
		evt_ff <= '{far_rx_bad: 1'b1, pll_locked: 1'b1, enable: 1'b1, default: '0};
		repeat (300) @(posedge mclk_in);
		evt_ff <= ev(0);
		repeat (5) @(posedge mclk_in);
		rd(5'h1a); check(got, 16'h05ff);
		rd(5'h1a); check(got, 16'h0000);
		$display("test counters done");
		// ------------------------------------------------------------
		// link control off keeps interleave and counts
		// ------------------------------------------------------------
		pulse(16, 5, 0);
		@(posedge mclk_in);
		evt_ff <= '{near_rx_bad: 1'b1, ilv_swap: 1'b1, pll_locked: 1'b1, enable: 1'b1,
			default: '0};
		repeat (3) @(posedge mclk_in);
		link_ctrl_ff <= 1'b0;
		evt_ff <= ev(0);
		repeat (6) @(posedge mclk_in);
		rd(5'h19); check(got, 16'h0020);
		rd(5'h1a); check(got, 16'h0300);
		@(posedge mclk_in);
		link_ctrl_ff <= 1'b1;
		repeat (5) @(posedge mclk_in);
		rd(5'h19); check(got, 16'h0000);
		$display("test link control done");
		conclude();
	end
endmodule : tb_psd_status_regs
